// *** core/fdx_regs.svh ***
// constants for the cascaded fifo host controller
// assumes a 125 MHz system clock; included by the controller and its package
`ifndef FDX_REGS_SVH
`define FDX_REGS_SVH
`define FDX_CLK_PERIOD_NS   8
// strobe low and high widths and reset width, ns (slowest grade)
`define FDX_T_STRB_NS       200
`define FDX_T_RECOV_NS      40
`define FDX_T_RESET_NS      235
`define FDX_T_RSSETUP_NS    180
`define FDX_CYC(ns)         (((ns) + `FDX_CLK_PERIOD_NS - 1) / `FDX_CLK_PERIOD_NS)
`define FDX_N_STRB          6'(`FDX_CYC(`FDX_T_STRB_NS))
`define FDX_N_RECOV         6'(`FDX_CYC(`FDX_T_RECOV_NS))
`define FDX_N_RESET         6'(`FDX_CYC(`FDX_T_RESET_NS))
`define FDX_N_RSSETUP       6'(`FDX_CYC(`FDX_T_RSSETUP_NS))
`define FDX_DATA_W          9
`define FDX_DEV_N           3
// one bit per device, low marks the ring head
`define FDX_FIRST_LOAD_SEL  3'h6
`endif

// *** core/fdx_pkg.sv ***
// types for the cascaded fifo host controller
// assumes fdx_regs.svh; state codes and the 6-bit count width are set here
`default_nettype none
`include "fdx_regs.svh"
package fdx_pkg;
  typedef enum logic [2:0] {
    FDX_RESET = 3'b000,
    FDX_IDLE  = 3'b001,
    FDX_LOW   = 3'b011,
    FDX_HIGH  = 3'b010,
    FDX_SETUP = 3'b110
  } fdx_state_t;
  typedef logic [5:0] fdx_cnt_t;
endpackage
`default_nettype wire

// *** core/fdx_host.sv ***
// host controller driving a ring of cascaded asynchronous fifos
// assumes shared write and read strobes, ringed expansion pins, or-ed flags
`timescale 1ns/1ps
`default_nettype none
`include "fdx_regs.svh"
module fdx_host (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  input  wire logic                   wr_req_i,
  input  wire logic [`FDX_DATA_W-1:0] wr_data_i,
  input  wire logic                   rd_req_i,
  input  wire logic [`FDX_DATA_W-1:0] fifo_q_i,
  input  wire logic                   full_flag_n_i,
  input  wire logic                   empty_flag_n_i,
  output logic                        wr_ready_o,
  output logic                        rd_ready_o,
  output logic                        rd_valid_o,
  output logic [`FDX_DATA_W-1:0]      rd_data_o,
  output logic [`FDX_DATA_W-1:0]      fifo_d_o,
  output logic                        write_strobe_n_o,
  output logic                        read_strobe_n_o,
  output logic                        reset_n_o,
  output logic                        reread_strobe_n_o,
  output logic [`FDX_DEV_N-1:0]       first_load_select_o
);
  // ------------------------------------------------------------
  // flag synchronisers
  // ------------------------------------------------------------
  logic [2:0] ff_sync_q;
  logic [2:0] ef_sync_q;
  logic       full_q;
  logic       empty_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ff_sync_q <= 3'h0;
      ef_sync_q <= 3'h0;
    end else begin
      ff_sync_q <= {ff_sync_q[1:0], full_flag_n_i};
      ef_sync_q <= {ef_sync_q[1:0], empty_flag_n_i};
    end
  end
  // second and third flop must agree before a flag moves
  // composite flags
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      full_q  <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      if (ff_sync_q[1] == ff_sync_q[2]) begin
        full_q <= ~ff_sync_q[2];
      end
      if (ef_sync_q[1] == ef_sync_q[2]) begin
        empty_q <= ~ef_sync_q[2];
      end
    end
  end
  // ------------------------------------------------------------
  // strobe sequencer
  // ------------------------------------------------------------
  fdx_pkg::fdx_state_t state_q;
  fdx_pkg::fdx_cnt_t   cnt_q;
  logic                is_rd_q;
  logic                cnt_done;
  assign cnt_done = (cnt_q == 6'h00);
  wire idle_ok = (state_q == fdx_pkg::FDX_IDLE) && cnt_done;
  assign wr_ready_o = idle_ok && !full_q;
  assign rd_ready_o = idle_ok && !empty_q && !wr_req_i;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= fdx_pkg::FDX_RESET;
      cnt_q   <= `FDX_N_RESET;
      is_rd_q <= 1'b0;
    end else begin
      if (!cnt_done) begin
        cnt_q <= cnt_q - 6'h01;
      end
      case (state_q)
        fdx_pkg::FDX_RESET: begin
          if (cnt_done) begin
            state_q <= fdx_pkg::FDX_SETUP;
            cnt_q   <= `FDX_N_RECOV;
          end
        end
        fdx_pkg::FDX_SETUP: begin
          if (cnt_done) begin
            state_q <= fdx_pkg::FDX_IDLE;
          end
        end
        fdx_pkg::FDX_IDLE: begin
          if (wr_ready_o && wr_req_i) begin
            state_q <= fdx_pkg::FDX_LOW;
            cnt_q   <= `FDX_N_STRB;
            is_rd_q <= 1'b0;
          end else if (rd_ready_o && rd_req_i) begin
            state_q <= fdx_pkg::FDX_LOW;
            cnt_q   <= `FDX_N_STRB;
            is_rd_q <= 1'b1;
          end
        end
        fdx_pkg::FDX_LOW: begin
          if (cnt_done) begin
            state_q <= fdx_pkg::FDX_HIGH;
            cnt_q   <= `FDX_N_RECOV;
          end
        end
        fdx_pkg::FDX_HIGH: begin
          if (cnt_done) begin
            state_q <= fdx_pkg::FDX_IDLE;
          end
        end
        default: begin
          state_q <= fdx_pkg::FDX_RESET;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // strobe spacing
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      write_strobe_n_o <= 1'b1;
      read_strobe_n_o  <= 1'b1;
    end else begin
      write_strobe_n_o <= !(state_q == fdx_pkg::FDX_IDLE && wr_ready_o && wr_req_i)
                          && !(state_q == fdx_pkg::FDX_LOW && !is_rd_q && !cnt_done);
      read_strobe_n_o  <= !(state_q == fdx_pkg::FDX_IDLE && !(wr_ready_o && wr_req_i)
                            && rd_ready_o && rd_req_i)
                          && !(state_q == fdx_pkg::FDX_LOW && is_rd_q && !cnt_done);
    end
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reset_n_o         <= 1'b0;
      reread_strobe_n_o <= 1'b1;
    end else begin
      reset_n_o         <= (state_q != fdx_pkg::FDX_RESET);
      reread_strobe_n_o <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      first_load_select_o <= `FDX_FIRST_LOAD_SEL;
    end else begin
      first_load_select_o <= `FDX_FIRST_LOAD_SEL;
    end
  end
  // ------------------------------------------------------------
  // data path
  // ------------------------------------------------------------
  // one width group
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_d_o   <= 9'h000;
      rd_data_o  <= 9'h000;
      rd_valid_o <= 1'b0;
    end else begin
      if (state_q == fdx_pkg::FDX_IDLE && wr_ready_o && wr_req_i) begin
        fifo_d_o <= wr_data_i;
      end
      rd_valid_o <= 1'b0;
      // capture on the next-to-last low cycle of the read strobe
      if (state_q == fdx_pkg::FDX_LOW && is_rd_q && cnt_q == 6'h01) begin
        rd_data_o  <= fifo_q_i;
        rd_valid_o <= 1'b1;
      end
    end
  end
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // cycles the present strobe has been held low
  fdx_pkg::fdx_cnt_t low_len_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      low_len_q <= 6'h00;
    end else if (!write_strobe_n_o || !read_strobe_n_o) begin
      low_len_q <= low_len_q + 6'h01;
    end else begin
      low_len_q <= 6'h00;
    end
  end
  AST_NO_BOTH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !(!write_strobe_n_o && !read_strobe_n_o)) else $error("both strobes low");
  AST_RESET_HIGH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !reset_n_o |-> write_strobe_n_o && read_strobe_n_o) else $error("strobe in reset");
  AST_WR_WIDTH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $fell(write_strobe_n_o) |-> !write_strobe_n_o [*7]) else $error("write too short");
  AST_RD_WIDTH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $fell(read_strobe_n_o) |-> !read_strobe_n_o [*7]) else $error("read too short");
  AST_WR_RECOV: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(write_strobe_n_o) |-> write_strobe_n_o [*5]) else $error("write recovery");
  AST_RD_RECOV: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(read_strobe_n_o) |-> read_strobe_n_o [*5]) else $error("read recovery");
  AST_STRB_LEN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ($rose(write_strobe_n_o) || $rose(read_strobe_n_o)) |-> low_len_q >= `FDX_N_STRB)
    else $error("strobe shorter than minimum");
  AST_RD_EMPTY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $fell(read_strobe_n_o) |-> !$past(empty_q) && $past(rd_req_i) && !$past(wr_req_i))
    else $error("read while empty");
  AST_WR_FULL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $fell(write_strobe_n_o) |-> !$past(full_q) && $past(wr_req_i))
    else $error("write while full");
  AST_IDLE_QUIET: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state_q == fdx_pkg::FDX_IDLE |-> write_strobe_n_o && read_strobe_n_o)
    else $error("strobe low while idle");
  AST_WR_DATA_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !write_strobe_n_o && !$past(write_strobe_n_o) |-> $stable(fifo_d_o))
    else $error("write data moved under strobe");
  AST_RD_IN_STROBE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_valid_o |-> !read_strobe_n_o)
    else $error("read data taken outside strobe");
  AST_NO_RT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    reread_strobe_n_o) else $error("retransmit used");
endmodule
`default_nettype wire

// *** test/fdx_ring_model.sv ***
// behavioural ring of cascaded asynchronous fifos facing the host
// assumes fdx_regs.svh; storage per device shortened by DEPTH
`timescale 1ns/1ps
`default_nettype none
`include "fdx_regs.svh"
module fdx_ring_model #(
  parameter int DEPTH = 4
) (
  input  wire logic                   write_strobe_n_i,
  input  wire logic                   read_strobe_n_i,
  input  wire logic                   reset_n_i,
  input  wire logic [`FDX_DATA_W-1:0] fifo_d_i,
  output logic      [`FDX_DATA_W-1:0] fifo_q_o,
  output logic                        full_flag_n_o,
  output logic                        empty_flag_n_o
);
  // --------------------------------------------------------------
  // storage shared round the ring
  // --------------------------------------------------------------
  localparam int TOTAL = DEPTH * `FDX_DEV_N;
  logic [`FDX_DATA_W-1:0] mem [TOTAL];
  logic [`FDX_DATA_W-1:0] last_q = '0;
  int                     wpos   = 0;
  int                     rpos   = 0;
  int                     count  = 0;
  always @(negedge reset_n_i) begin
    wpos = 0;
    rpos = 0;
    count = 0;
  end
  // write token passes at physical end
  always @(posedge write_strobe_n_i) begin
    if (reset_n_i === 1'b1 && count < TOTAL) begin
      mem[wpos] = fifo_d_i;
      wpos = (wpos + 1) % TOTAL;
      count++;
    end
  end
  // read token passes at physical end, never while empty
  always @(posedge read_strobe_n_i) begin
    if (reset_n_i === 1'b1 && count > 0) begin
      last_q = mem[rpos];
      rpos = (rpos + 1) % TOTAL;
      count--;
    end
  end
  // released data lines show the inverse of the last word
  assign fifo_q_o = (!read_strobe_n_i && count != 0) ? mem[rpos] : ~last_q;
  assign full_flag_n_o  = (count != TOTAL);
  assign empty_flag_n_o = (count != 0);
endmodule
`default_nettype wire

// *** test/fifo_depth_expansion_token_tb_top.sv ***
// self-checking bench for the cascaded fifo host controller
// assumes fdx_ring_model as the far side
`timescale 1ns/1ps
`default_nettype none
`include "fdx_regs.svh"
module fifo_depth_expansion_token_tb_top;
  localparam int DEPTH = 4;
  localparam int TOTAL = DEPTH * `FDX_DEV_N;
  logic clk = 1'b0, rst = 1'b1, wr_req = 1'b0, rd_req = 1'b0;
  logic wr_ready, rd_ready, rd_valid, wr_strb_n, rd_strb_n, rst_n, reread_n, full_n, empty_n;
  logic [`FDX_DATA_W-1:0] wr_data = '0, fifo_q, rd_data, fifo_d;
  logic [`FDX_DEV_N-1:0]  first_sel;
  int miscompares = 0, n_tests = 0;
  fdx_host uut (.clk_sys_i(clk), .rst_i(rst), .wr_req_i(wr_req), .wr_data_i(wr_data),
    .rd_req_i(rd_req), .fifo_q_i(fifo_q), .full_flag_n_i(full_n), .empty_flag_n_i(empty_n),
    .wr_ready_o(wr_ready), .rd_ready_o(rd_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .fifo_d_o(fifo_d), .write_strobe_n_o(wr_strb_n), .read_strobe_n_o(rd_strb_n),
    .reset_n_o(rst_n), .reread_strobe_n_o(reread_n), .first_load_select_o(first_sel));
  fdx_ring_model #(.DEPTH(DEPTH)) ring (.write_strobe_n_i(wr_strb_n),
    .read_strobe_n_i(rd_strb_n), .reset_n_i(rst_n), .fifo_d_i(fifo_d), .fifo_q_o(fifo_q),
    .full_flag_n_o(full_n), .empty_flag_n_o(empty_n));
  initial begin
    forever #4 clk = ~clk;
  end
  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic write_word(input logic [8:0] d);
    wr_data = d;
    wr_req = 1'b1;
    for (int i = 0; i < 200 && wr_ready !== 1'b1; i++) @(negedge clk);
    check(9'(wr_ready), 9'h001, "write not taken");
    @(negedge clk);
    wr_req = 1'b0;
    check(9'(wr_strb_n), 9'h000, "write strobe not low");
    check(fifo_d, d, "data to fifo");
    @(negedge clk);
  endtask
  task automatic read_word(input logic [8:0] e);
    rd_req = 1'b1;
    for (int i = 0; i < 200 && rd_ready !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    rd_req = 1'b0;
    check(9'(rd_strb_n), 9'h000, "read strobe not low");
    for (int i = 0; i < 60 && rd_valid !== 1'b1; i++) @(negedge clk);
    check(9'(rd_valid), 9'h001, "read data never valid");
    check(rd_data, e, "read data");
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic test_fill_drain();
    for (int k = 0; k < TOTAL; k++) write_word(9'(9'h100 + k));
    repeat (40) @(negedge clk);
    check(9'(wr_ready), 9'h000, "write offered when full");
    for (int k = 0; k < TOTAL; k++) read_word(9'(9'h100 + k));
    repeat (40) @(negedge clk);
    check(9'(rd_ready), 9'h000, "read offered when empty");
  endtask
  task automatic test_wrap();
    write_word(9'h0a5);
    write_word(9'h15a);
    read_word(9'h0a5);
    read_word(9'h15a);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    check(9'(rst_n), 9'h000, "device reset not held");
    check(9'({wr_strb_n, rd_strb_n}), 9'h003, "strobe active in reset");
    @(negedge clk);
    rst = 1'b0;
    check(9'(first_sel), 9'h006, "first device pick");
    check(9'(reread_n), 9'h001, "reread used");
    test_fill_drain();
    test_wrap();
    wrap_up();
  end
  initial begin
    repeat (8000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
